/* hdl/ulm_pkg.sv */
package ulm_pkg;
  // register indices on the 3-bit address port
  localparam logic [2:0] ADR_DATA  = 3'h0;  // data, or divisor low when divisor access
  localparam logic [2:0] ADR_DIVHI = 3'h1;  // divisor high, only when divisor access
  localparam logic [2:0] ADR_FIFO  = 3'h2;  // fifo_control, write only
  localparam logic [2:0] ADR_LINE  = 3'h3;  // line_control
  localparam logic [2:0] ADR_MODEM = 3'h4;  // modem_control
  localparam logic [2:0] ADR_LSTAT = 3'h5;  // line_status
  localparam logic [2:0] ADR_MSTAT = 3'h6;  // modem_status_register
  localparam logic [2:0] ADR_EFR   = 3'h7;  // enhanced_feature_register
  // field positions
  localparam int FC_EN    = 0;
  localparam int FC_TXLO  = 4;
  localparam int FC_RXLO  = 6;
  localparam int LC_STOP  = 2;
  localparam int LC_PEN   = 3;
  localparam int LC_EVEN  = 4;
  localparam int LC_FORCE = 5;
  localparam int LC_BRK   = 6;
  localparam int LC_DLAB  = 7;
  localparam int MC_DTR   = 0;
  localparam int MC_RTS   = 1;
  localparam int MC_OUT1  = 2;
  localparam int MC_OUT2  = 3;
  localparam int MC_LOOP  = 4;
  localparam int MC_XANY  = 5;
  localparam int MC_IR    = 6;
  localparam int MC_PRE   = 7;
  localparam int EF_ENH   = 4;
  localparam int EF_ARTS  = 6;
  // reset values
  localparam logic [7:0] RST_FIFO  = 8'h00;
  localparam logic [7:0] RST_LINE  = 8'h00;
  localparam logic [7:0] RST_MODEM = 8'h00;
  localparam logic [7:0] RST_EFR   = 8'h00;
  localparam logic [7:0] RST_DIV   = 8'h00;
  // prescaler divide-by-four terminal count
  localparam logic [1:0] PRE_LAST  = 2'h3;

  // trigger code to character count (1, 4, 8, 14)
  function automatic logic [4:0] ulm_trig(input logic [1:0] code);
    case (code)
      2'h0:    ulm_trig = 5'h01;
      2'h1:    ulm_trig = 5'h04;
      2'h2:    ulm_trig = 5'h08;
      default: ulm_trig = 5'h0e;
    endcase
  endfunction : ulm_trig

  // character format handed to the shifters
  typedef struct packed {
    logic [3:0] data_bits;   // 5..8
    logic [1:0] stop_half;   // stop length in half bits: 2, 3 or 4
    logic       par_en;      // parity bit present
    logic       par_force;   // parity bit is the constant par_val
    logic       par_even;    // even parity when not forced
    logic       par_val;     // forced parity level
  } ulm_frm_s;
endpackage : ulm_pkg

/* hdl/ulm_ctrl.sv */
// Operation
// - tx trigger level 1/4/8/14 from fifo bits 5:4
// - tx interrupt below level, else on empty
// - tx trigger bits writable only when enhanced
// - rx trigger level bits 7:6, interrupt crossing
// - word length 5 to 8 from bits 1:0
// - one stop, else 1.5 or 2
// - bit 3 enables parity generate and check
// - bit 4 selects odd or even parity
// - bit 5 forces parity to constant level
// - break bit holds transmit output low outside loopback
// - bit 7 maps shared addresses to divisor
// - terminal ready pin is inverse of bit 0 outside loopback
// - request to send pin inverse of bit 1 outside loopback
// - bit 2 sets infrared rx polarity, loop ring
// - bit 3 enables interrupt pin outside loopback, drives output two
// - bit 4 selects internal loopback
// - any character resumes transmit, stored unless flow
// - bit 6 routes through infrared coder
// - prescaler divides baud clock by one or four
// - line status bit 0 shows receive data held
// - resume, infrared, prescaler bits need enhanced enable
// - fifo control written only with bit 0 set
// - loopback ring status follows modem bit 2
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl
  import ulm_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [2:0] ADDR,        // register index
  input  wire logic [7:0] WDATA,       // write data
  input  wire logic       WR,          // write strobe
  input  wire logic       RD,          // read strobe
  output logic      [7:0] RDATA,       // read data, cycle after RD
  input  wire logic [7:0] RX_DATA,     // head of receive fifo
  output logic            TX_WRITE,    // transmit holding write pulse
  output logic            RX_READ,     // receive holding read pulse
  input  wire logic [4:0] TX_COUNT,    // characters in transmit fifo
  input  wire logic [4:0] RX_COUNT,    // characters in receive fifo
  output logic            TX_INT,      // transmit ready request
  output logic            RX_INT,      // receive trigger request
  output ulm_frm_s        FRAME,       // character format
  output logic     [15:0] DIVISOR,     // baud divisor
  output logic            BAUD_EN,     // prescaled baud clock enable
  input  wire logic       TX_SER,      // raw serial from transmit shifter
  input  wire logic       IR_TX,       // infrared encoder output
  output logic            TXD,         // serial transmit pin
  input  wire logic       RXD,         // serial receive pin
  output logic            RX_SER,      // serial into receive path
  output logic            IR_SEL,      // infrared coder in use
  input  wire logic       RX_DONE,     // one character received
  input  wire logic       RX_FLOWCHR,  // that character is a flow character
  input  wire logic       SW_FLOW_EN,  // software flow control on
  output logic            TX_RESUME,   // resume stopped transmit pulse
  output logic            RX_STORE,    // store received character pulse
  output logic            AUTO_RTS,    // automatic rts flow enabled
  input  wire logic       INT_REQ,     // combined interrupt from sources
  output logic            INT_O,       // interrupt pin level
  output logic            INT_OE,      // interrupt pin enable
  output logic            DTR_N,       // terminal ready pin
  output logic            RTS_N,       // request to send pin
  output logic            OUT2_N,      // general output two pin
  input  wire logic       CTS_N,       // clear to send pin
  input  wire logic       DSR_N,       // set ready pin
  input  wire logic       RI_N,        // ring_indicator_in pin
  input  wire logic       CD_N         // carrier detect pin
);

  // control registers
  logic [7:0] fifo_ff;         // fifo_control
  logic [7:0] line_ff;         // line_control
  logic [7:0] modem_ff;        // modem_control
  logic [7:0] efr_ff;          // enhanced_feature_register
  logic [7:0] divlo_ff;        // divisor low byte
  logic [7:0] divhi_ff;        // divisor_high
  logic [7:0] rdata_ff;        // read data holding
  logic       above_ff;        // last reload filled past tx level
  logic [1:0] pre_ff;          // prescaler counter
  logic       baud_ff;         // registered baud enable
  logic       txd_ff;          // registered serial pin
  logic       resume_ff;       // registered resume pulse
  logic       store_ff;        // registered store pulse

  // decoded strobes
  wire logic dlab   = line_ff[LC_DLAB];
  wire logic enh    = efr_ff[EF_ENH];
  wire logic loop   = modem_ff[MC_LOOP];
  wire logic w_data = WR && ADDR == ADR_DATA && !dlab;
  wire logic w_divl = WR && ADDR == ADR_DATA && dlab;
  wire logic w_divh = WR && ADDR == ADR_DIVHI && dlab;
  wire logic w_fifo = WR && ADDR == ADR_FIFO && WDATA[FC_EN];
  wire logic w_line = WR && ADDR == ADR_LINE;
  wire logic w_mdm  = WR && ADDR == ADR_MODEM;
  wire logic w_efr  = WR && ADDR == ADR_EFR;
  wire logic r_data = RD && ADDR == ADR_DATA && !dlab;

  // next values of the write-gated registers
  logic [7:0] nxt_fifo;
  logic [7:0] nxt_modem;

  // fifo bits land only with enable set; tx trigger kept unless enhanced
  always_comb begin
    nxt_fifo = fifo_ff;
    if (w_fifo) begin
      nxt_fifo = WDATA;
      if (!enh) begin
        nxt_fifo[FC_TXLO+1:FC_TXLO] = fifo_ff[FC_TXLO+1:FC_TXLO];
      end
    end
  end

  // enhanced-only bits of modem control hold their value otherwise
  always_comb begin
    nxt_modem = modem_ff;
    if (w_mdm) begin
      nxt_modem = WDATA;
      if (!enh) begin
        nxt_modem[MC_PRE]  = modem_ff[MC_PRE];
        nxt_modem[MC_IR]   = modem_ff[MC_IR];
        nxt_modem[MC_XANY] = modem_ff[MC_XANY];
      end
    end
  end

  // register storage, all zero after reset
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fifo_ff  <= RST_FIFO;
      line_ff  <= RST_LINE;
      modem_ff <= RST_MODEM;
      efr_ff   <= RST_EFR;
      divlo_ff <= RST_DIV;
      divhi_ff <= RST_DIV;
    end else begin
      fifo_ff  <= nxt_fifo;
      modem_ff <= nxt_modem;
      if (w_line) line_ff  <= WDATA;
      if (w_efr)  efr_ff   <= WDATA;
      if (w_divl) divlo_ff <= WDATA;
      if (w_divh) divhi_ff <= WDATA;
    end
  end

  // shared address goes to data path only without divisor access
  assign TX_WRITE = w_data;
  assign RX_READ  = r_data;
  assign DIVISOR  = {divhi_ff, divlo_ff};

  // trigger levels
  wire logic [4:0] tx_lvl = ulm_trig(fifo_ff[FC_TXLO+1:FC_TXLO]);
  wire logic [4:0] rx_lvl = ulm_trig(fifo_ff[FC_RXLO+1:FC_RXLO]);

  // remember whether the last reload got above the tx level
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      above_ff <= 1'b0;
    end else if (TX_COUNT > tx_lvl) begin
      above_ff <= 1'b1;
    end else if (TX_COUNT == 5'h00) begin
      above_ff <= 1'b0;
    end
  end

  // a short reload only interrupts once it has drained
  assign TX_INT = above_ff ? (TX_COUNT < tx_lvl) : (TX_COUNT == 5'h00);
  assign RX_INT = RX_COUNT >= rx_lvl;

  // character format
  always_comb begin
    FRAME.data_bits = 4'h5 + {2'h0, line_ff[1:0]};
    if (!line_ff[LC_STOP]) begin
      FRAME.stop_half = 2'h2;
    end else if (line_ff[1:0] == 2'h0) begin
      FRAME.stop_half = 2'h3;
    end else begin
      FRAME.stop_half = 2'h0;  // four half bits wraps; shifter reads 0 as two stops
    end
    FRAME.par_en    = line_ff[LC_PEN];
    FRAME.par_even  = line_ff[LC_EVEN];
    FRAME.par_force = line_ff[LC_FORCE];
    FRAME.par_val   = !line_ff[LC_EVEN];
  end

  // status reads
  wire logic       rx_ready = RX_COUNT != 5'h00;
  wire logic [7:0] lstat = {7'h00, rx_ready};
  wire logic [3:0] mstat_lo = 4'h0;  // delta bits live in the status block
  wire logic [3:0] mstat_hi = loop ?
    {modem_ff[MC_OUT2], modem_ff[MC_OUT1], modem_ff[MC_DTR], modem_ff[MC_RTS]} :
    {!CD_N, !RI_N, !DSR_N, !CTS_N};
  wire logic [7:0] mstat = {mstat_hi, mstat_lo};

  // read multiplexer; fifo_control is write only and reads as zero
  logic [7:0] rd_mux;
  always_comb begin
    if (ADDR == ADR_DATA) begin
      rd_mux = dlab ? divlo_ff : RX_DATA;
    end else if (ADDR == ADR_DIVHI) begin
      rd_mux = dlab ? divhi_ff : 8'h00;
    end else if (ADDR == ADR_LINE) begin
      rd_mux = line_ff;
    end else if (ADDR == ADR_MODEM) begin
      rd_mux = modem_ff;
    end else if (ADDR == ADR_LSTAT) begin
      rd_mux = lstat;
    end else if (ADDR == ADR_MSTAT) begin
      rd_mux = mstat;
    end else if (ADDR == ADR_EFR) begin
      rd_mux = efr_ff;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) rdata_ff <= 8'h00;
    else       rdata_ff <= RD ? rd_mux : 8'h00;
  end
  assign RDATA = rdata_ff;

  // prescaler: a baud enable every cycle or every fourth
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pre_ff  <= 2'h0;
      baud_ff <= 1'b0;
    end else begin
      pre_ff  <= pre_ff + 2'h1;
      baud_ff <= !modem_ff[MC_PRE] || pre_ff == PRE_LAST;
    end
  end
  assign BAUD_EN = baud_ff;

  // serial output: break beats infrared and shifter data, loopback parks the pin at mark
  logic tx_line;
  always_comb begin
    if (line_ff[LC_BRK])       tx_line = 1'b0;
    else if (modem_ff[MC_IR])  tx_line = IR_TX;
    else                       tx_line = TX_SER;
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) txd_ff <= 1'b1;
    else       txd_ff <= loop ? 1'b1 : tx_line;
  end
  assign TXD    = txd_ff;
  assign IR_SEL = modem_ff[MC_IR];

  // receive path: loopback takes the internal line, infrared is
  // normalised to active high pulses for the decoder
  wire logic ir_rx = modem_ff[MC_OUT1] ? RXD : !RXD;
  assign RX_SER = loop ? tx_line : (modem_ff[MC_IR] ? ir_rx : RXD);

  // any character resume, flow characters are not stored when flow is on
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      resume_ff <= 1'b0;
      store_ff  <= 1'b0;
    end else begin
      resume_ff <= RX_DONE && modem_ff[MC_XANY];
      store_ff  <= RX_DONE && !(RX_FLOWCHR && SW_FLOW_EN);
    end
  end
  assign TX_RESUME = resume_ff;
  assign RX_STORE  = store_ff;
  assign AUTO_RTS  = efr_ff[EF_ARTS];

  // modem outputs are active low copies outside loopback, general output two always
  assign DTR_N  = !modem_ff[MC_DTR] || loop;
  assign RTS_N  = !modem_ff[MC_RTS] || loop;
  assign OUT2_N = !modem_ff[MC_OUT2];
  assign INT_OE = modem_ff[MC_OUT2] && !loop;
  assign INT_O  = INT_REQ;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_fifo_wr_on;
    WR && ADDR == ADR_FIFO && WDATA[FC_EN];
  endsequence

  a_fifo_wr_gate: assert property (
    WR && ADDR == ADR_FIFO && !WDATA[FC_EN] |=> $stable(fifo_ff))
    else $error("fifo control changed without enable bit");
  a_tx_trig_lock: assert property ((s_fifo_wr_on and !enh)
    |=> fifo_ff[5:4] == $past(fifo_ff[5:4]))
    else $error("tx trigger changed without enhanced enable");
  a_rx_trig_take: assert property (s_fifo_wr_on
    |=> fifo_ff[7:6] == $past(WDATA[7:6]))
    else $error("rx trigger not taken");
  a_enh_bits_lock: assert property (WR && ADDR == ADR_MODEM && !enh
    |=> modem_ff[7:5] == $past(modem_ff[7:5]))
    else $error("enhanced modem bits changed");
  a_rx_int_level: assert property (RX_INT == (RX_COUNT >= ulm_trig(fifo_ff[7:6])))
    else $error("rx interrupt level wrong");
  a_tx_empty_int: assert property (TX_COUNT == 5'h00 |-> TX_INT)
    else $error("tx interrupt missing on empty fifo");
  a_break_hold: assert property (line_ff[LC_BRK] && !loop |=> !TXD)
    else $error("break not driven low");
  a_word_len: assert property (FRAME.data_bits == 4'h5 + {2'h0, line_ff[1:0]})
    else $error("word length wrong");
  a_stop_one: assert property (!line_ff[LC_STOP] |-> FRAME.stop_half == 2'h2)
    else $error("stop length wrong");
  a_force_par: assert property (line_ff[LC_FORCE] |-> FRAME.par_val != line_ff[LC_EVEN])
    else $error("forced parity level wrong");
  a_data_ready: assert property (RD && ADDR == ADR_LSTAT
    |=> RDATA[0] == ($past(RX_COUNT) != 5'h00))
    else $error("data ready status wrong");
  a_loop_ring: assert property (RD && ADDR == ADR_MSTAT && loop
    |=> RDATA[6] == $past(modem_ff[MC_OUT1]))
    else $error("loopback ring status wrong");
  a_div_access: assert property (WR && ADDR == ADR_DATA && dlab |-> !TX_WRITE)
    else $error("data write during divisor access");
  a_pre_quarter: assert property (modem_ff[MC_PRE] && $stable(modem_ff[MC_PRE])
    && nxt_modem[MC_PRE] && BAUD_EN |=> !BAUD_EN [*2])
    else $error("prescaler enable too often");
  a_dtr_pin: assert property (!loop |-> DTR_N == !modem_ff[MC_DTR])
    else $error("terminal ready pin wrong");
  a_int_enable: assert property (INT_OE |-> modem_ff[MC_OUT2] && !OUT2_N)
    else $error("interrupt enable and output two disagree");
  a_resume_any: assert property (RX_DONE && modem_ff[MC_XANY] |=> TX_RESUME)
    else $error("resume missing");

endmodule : ulm_ctrl
`default_nettype wire

/* test/ulm_remote.sv */
`timescale 1ns/1ps
`default_nettype none
// far-end transceiver: echoes our line and drives the modem inputs
module ulm_remote (
  input  wire logic CLK,    // device clock, for the echo register
  input  wire logic TXD,    // serial line from the device
  input  wire logic RING,   // bench asks the far end to ring
  output logic      RXD,    // serial line towards the device
  output logic      CTS_N,  // clear to send, asserted
  output logic      DSR_N,  // set ready, asserted
  output logic      RI_N,   // ring line, active low
  output logic      CD_N    // carrier detect, asserted
);
  // echo one cycle late, like a looped cable with some delay;
  // the device parks its line at mark in reset, so the echo idles high
  always @(posedge CLK) begin
    RXD <= TXD;
  end
  assign RI_N  = !RING;
  assign CTS_N = 1'b0;
  assign DSR_N = 1'b0;
  assign CD_N  = 1'b0;
endmodule : ulm_remote
`default_nettype wire

/* test/ulm_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl_tb;
  import ulm_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0;  // clock, reset, strobes
  logic [2:0] addr = 3'h0;                                  // register index
  logic [7:0] wdata = 8'h00, rdata, rx_data = 8'h5a;        // bus data, fifo head
  logic [4:0] tx_count = 5'h00, rx_count = 5'h00;           // fifo fills
  logic tx_ser = 1'b1, ir_tx = 1'b0, rx_done = 1'b0, rx_flowchr = 1'b0;
  logic sw_flow_en = 1'b0, int_req = 1'b0, ring = 1'b0;
  logic tx_int, rx_int, baud_en, txd, rx_ser, ir_sel, tx_resume, rx_store, auto_rts;
  logic int_o, int_oe, dtr_n, rts_n, out2_n, rxd, cts_n, dsr_n, ri_n, cd_n;
  ulm_frm_s    frame;    // character format out
  logic [15:0] divisor;  // baud divisor out
  int miscompares = 0, tests_run = 0;
  logic tx_write, rx_read;     // data path strobes out
  int   n_txw = 0, n_rxr = 0;  // data path strobes seen

  ulm_ctrl ulm_ctrl_inst (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .RX_DATA(rx_data), .TX_WRITE(tx_write), .RX_READ(rx_read),
    .TX_COUNT(tx_count), .RX_COUNT(rx_count), .TX_INT(tx_int), .RX_INT(rx_int),
    .FRAME(frame), .DIVISOR(divisor), .BAUD_EN(baud_en), .TX_SER(tx_ser), .IR_TX(ir_tx),
    .TXD(txd), .RXD(rxd), .RX_SER(rx_ser), .IR_SEL(ir_sel), .RX_DONE(rx_done),
    .RX_FLOWCHR(rx_flowchr), .SW_FLOW_EN(sw_flow_en), .TX_RESUME(tx_resume),
    .RX_STORE(rx_store), .AUTO_RTS(auto_rts), .INT_REQ(int_req), .INT_O(int_o),
    .INT_OE(int_oe), .DTR_N(dtr_n), .RTS_N(rts_n), .OUT2_N(out2_n), .CTS_N(cts_n),
    .DSR_N(dsr_n), .RI_N(ri_n), .CD_N(cd_n));
  ulm_remote ulm_remote_inst (.CLK(clk), .TXD(txd), .RING(ring), .RXD(rxd), .CTS_N(cts_n),
    .DSR_N(dsr_n), .RI_N(ri_n), .CD_N(cd_n));

  // 20 ns period
  always #10 clk = ~clk;

  // count data path strobes at the edge that takes them
  always @(posedge clk) begin
    if (tx_write) n_txw++;
    if (rx_read)  n_rxr++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // wait edges, then let their updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // one-cycle write; effect visible once the taking edge has passed
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdc
  // fill counts change, then two edges so the above-level flag settles
  task automatic setc(input logic [4:0] t, input logic [4:0] r);
    @(posedge clk);
    tx_count <= t;
    rx_count <= r;
    cyc(2);
  endtask : setc

  task automatic t_reset;
    rdc(ADR_LINE, 8'h00);
    rdc(ADR_MODEM, 8'h00);
    chk({dtr_n, rts_n, out2_n, int_oe, txd}, 5'h1d);
    $display("test reset done");
  endtask : t_reset

  task automatic t_fifo;
    rdc(ADR_FIFO, 8'h00);                 // write-only place reads zero
    wr(ADR_FIFO, 8'hf1);                  // tx bits locked while not enhanced
    setc(5'd15, 5'd13);
    chk({tx_int, rx_int}, 2'b00);
    setc(5'd13, 5'd14);
    chk({tx_int, rx_int}, 2'b01);
    wr(ADR_FIFO, 8'h00);                  // enable bit low: whole write dropped
    setc(5'd0, 5'd13);
    chk({tx_int, rx_int}, 2'b10);
    wr(ADR_EFR, 8'h10);
    wr(ADR_FIFO, 8'h11);                  // tx level 4, rx level 1
    setc(5'd5, 5'd1);
    chk({tx_int, rx_int}, 2'b01);
    setc(5'd4, 5'd0);
    chk({tx_int, rx_int}, 2'b00);
    setc(5'd3, 5'd0);
    chk({tx_int, rx_int}, 2'b10);
    wr(ADR_FIFO, 8'h31);                  // tx level 14, never filled above it
    setc(5'd0, 5'd0);
    setc(5'd5, 5'd0);
    chk({tx_int, rx_int}, 2'b00);
    setc(5'd0, 5'd0);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_format;
    logic [7:0] pc [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h00};
    logic [3:0] pe [5] = '{4'h9, 4'ha, 4'hd, 4'he, 4'h1};
    for (int i = 0; i < 4; i++) begin
      wr(ADR_LINE, 8'h04 | 8'(i));
      chk(frame.data_bits, 16'(5 + i));
      chk(frame.stop_half, (i == 0) ? 16'h3 : 16'h0);
    end
    // parity table: odd, even, forced mark, forced space, none
    for (int i = 0; i < 5; i++) begin
      wr(ADR_LINE, pc[i]);
      chk(frame.stop_half, 16'h2);
      chk({frame.par_en, frame.par_force, frame.par_even, frame.par_val}, pe[i]);
    end
    wr(ADR_LINE, 8'h43);
    cyc(1);
    chk(txd, 1'b0);
    cyc(5);
    chk(txd, 1'b0);
    wr(ADR_LINE, 8'h03);
    cyc(1);
    chk(txd, 1'b1);
    $display("test format done");
  endtask : t_format

  task automatic t_divisor;
    wr(ADR_LINE, 8'h80);
    wr(ADR_DATA, 8'h34);
    wr(ADR_DIVHI, 8'h12);
    chk(divisor, 16'h1234);
    rdc(ADR_DATA, 8'h34);
    chk(16'(n_txw + n_rxr), 16'h0);
    rdc(ADR_LINE, 8'h80);
    wr(ADR_LINE, 8'h03);
    rdc(ADR_DATA, 8'h5a);
    wr(ADR_DATA, 8'h77);
    chk(16'(n_txw), 16'h1);
    chk(16'(n_rxr), 16'h1);
    $display("test divisor done");
  endtask : t_divisor

  task automatic t_modem;
    int_req <= 1'b1;
    wr(ADR_MODEM, 8'h0b);
    chk({dtr_n, rts_n, out2_n, int_oe, int_o}, 5'h03);
    rdc(ADR_MODEM, 8'h0b);
    wr(ADR_MODEM, 8'h14);                               // loopback, ring bit
    tx_ser <= 1'b0;
    cyc(1);
    chk({txd, int_oe, rx_ser}, 3'b100);
    rdc(ADR_MSTAT, 8'h40);
    tx_ser <= 1'b1;
    wr(ADR_MODEM, 8'h00);
    ring <= 1'b1;
    rdc(ADR_MSTAT, 8'hf0);                              // pins seen again
    ring <= 1'b0;
    rdc(ADR_MSTAT, 8'hb0);
    chk({dtr_n, rts_n, out2_n, int_oe}, 4'he);
    rx_count <= 5'd1;
    rdc(ADR_LSTAT, 8'h01);
    rx_count <= 5'd0;
    rdc(ADR_LSTAT, 8'h00);
    $display("test modem done");
  endtask : t_modem

  task automatic t_enh;
    int n;
    wr(ADR_EFR, 8'h00);
    wr(ADR_MODEM, 8'he0);
    rdc(ADR_MODEM, 8'h00);
    wr(ADR_EFR, 8'h50);
    chk(auto_rts, 1'b1);
    wr(ADR_MODEM, 8'h40);
    cyc(1);
    chk({ir_sel, txd, rx_ser}, {2'b10, !rxd});
    wr(ADR_MODEM, 8'h44);
    chk(rx_ser, rxd);
    for (int k = 0; k < 2; k++) begin
      wr(ADR_MODEM, k ? 8'h00 : 8'h80);
      n = 0;
      repeat (16) begin
        cyc(1);
        n += int'(baud_en);
      end
      chk(16'(n), k ? 16'd16 : 16'd4);
    end
    $display("test enhanced done");
  endtask : t_enh

  // any-character resume, with and without the flow character filter
  task automatic t_resume;
    logic [7:0] mc [3] = '{8'h20, 8'h20, 8'h00};
    logic [1:0] ex [3] = '{2'b11, 2'b10, 2'b01};
    for (int k = 0; k < 3; k++) begin
      wr(ADR_MODEM, mc[k]);
      @(posedge clk);
      rx_done    <= 1'b1;
      rx_flowchr <= (k == 1);
      sw_flow_en <= (k == 1);
      @(posedge clk);
      rx_done    <= 1'b0;
      #1;
      chk({tx_resume, rx_store}, ex[k]);
    end
    $display("test resume done");
  endtask : t_resume

  task automatic print_verdict;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // reset for 12 cycles, then the scenarios in order
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_fifo();
    t_format();
    t_divisor();
    t_modem();
    t_enh();
    t_resume();
    print_verdict();
  end
endmodule : ulm_ctrl_tb
`default_nettype wire
